// ===== design/tsc_trap_status_control.sv
// Decided for this implementation: the strobed register port and the register offsets.
`default_nettype none
// Behaviour
// (RL1) a math fault trap sets the math fault flag at bit 4; with no such trap it stays 0 (here a written 1 at bit 4 sets it too).
// (RL2) a bad address trap sets the bad address flag at bit 3; otherwise it stays 0 (here a written 1 at bit 3 sets it too).
// (RL3) a stack fault trap sets the stack fault flag at bit 2; otherwise it stays 0 (here a written 1 at bit 2 sets it too).
// (RL4) a clock loss trap sets the clock loss flag at bit 1; otherwise it stays 0 (here a written 1 at bit 1 sets it too).
// (RL5) bit 0 has no storage and always reads 0 whatever was written.
// (RL6) each flag stays set until software writes 0 to it, and every field reads 0 after reset.
module tsc_trap_status_control #(
	parameter int unsigned ADDR_W = tsc_pkg::ADDR_W
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic math_fault_in,
	input wire logic bad_address_in,
	input wire logic stack_fault_in,
	input wire logic clock_loss_in,
	output logic [15:0] rdata_out,
	output logic [3:0] trap_flags_out,
	output logic nest_disable_out,
	output logic irq_out
);
	// ****************************************
	// helpers
	// ****************************************
	// flag vector order: {math, bad address, stack, clock loss}
	function automatic logic [15:0] tsc_place(input logic [3:0] f);
		logic [15:0] w;
		w = 16'h0000;
		w[tsc_pkg::MATH_FAULT_BIT] = f[3];
		w[tsc_pkg::BAD_ADDRESS_BIT] = f[2];
		w[tsc_pkg::STACK_FAULT_BIT] = f[1];
		w[tsc_pkg::CLOCK_LOSS_BIT] = f[0];
		return w;
	endfunction : tsc_place

	function automatic logic [3:0] tsc_pick(input logic [15:0] w);
		return {w[tsc_pkg::MATH_FAULT_BIT], w[tsc_pkg::BAD_ADDRESS_BIT],
			w[tsc_pkg::STACK_FAULT_BIT], w[tsc_pkg::CLOCK_LOSS_BIT]};
	endfunction : tsc_pick

	function automatic logic tsc_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
		return (a == ADDR_W'(off));
	endfunction : tsc_hit

	// ****************************************
	// decode
	// ****************************************
	logic hit_trap;
	logic hit_stat;
	logic hit_mask;
	logic trap_wr;
	logic mask_wr;
	logic stat_rd;
	logic [3:0] trap_events;

	assign hit_trap = tsc_hit(addr_in, tsc_pkg::TRAP_OFF);
	assign hit_stat = tsc_hit(addr_in, tsc_pkg::STAT_OFF);
	assign hit_mask = tsc_hit(addr_in, tsc_pkg::MASK_OFF);
	// the slave never stalls, so a strobe and a select make a one-cycle enable
	assign trap_wr = wr_in && hit_trap;
	assign mask_wr = wr_in && hit_mask;
	assign stat_rd = rd_in && hit_stat;
	assign trap_events = {math_fault_in, bad_address_in, stack_fault_in, clock_loss_in}; // RL1 RL2 RL3 RL4

	// ****************************************
	// trap flags
	// ****************************************
	tsc_flag_if #(.N(tsc_pkg::NFLAG)) trap_if ();

	assign trap_if.event_set = trap_events; // RL1 RL2 RL3 RL4
	// a written 1 sets a flag too, so software can raise a trap by hand
	assign trap_if.load = trap_wr; // RL6
	assign trap_if.load_val = tsc_pick(wdata_in); // RL6

	tsc_flag_bank #(
		.N(tsc_pkg::NFLAG),
		.RESET_VAL(tsc_pkg::FLAG_RESET)
	) u_trap_bank (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.port_if(trap_if)
	);

	// ****************************************
	// upper control bits, plain storage
	// ****************************************
	logic [10:0] upper_q;

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			upper_q <= tsc_pkg::UPPER_RESET; // RL6
		end else if (trap_wr) begin
			upper_q <= wdata_in[tsc_pkg::UPPER_LSB +: tsc_pkg::UPPER_W];
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	// status clears on read; the bank ors new events over the clear
	tsc_flag_if #(.N(tsc_pkg::NFLAG)) stat_if ();

	assign stat_if.event_set = trap_events;
	assign stat_if.load = stat_rd;
	assign stat_if.load_val = tsc_pkg::FLAG_RESET;

	tsc_flag_bank #(
		.N(tsc_pkg::NFLAG),
		.RESET_VAL(tsc_pkg::FLAG_RESET)
	) u_stat_bank (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.port_if(stat_if)
	);

	// ****************************************
	// interrupt mask
	// ****************************************
	logic [3:0] mask_q;
	logic [3:0] pending;

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			mask_q <= tsc_pkg::MASK_RESET;
		end else if (mask_wr) begin
			mask_q <= tsc_pick(wdata_in);
		end
	end

	// irq is a level: it holds until the status read or the mask drops it
	assign pending = stat_if.flags & mask_q;

	// ****************************************
	// named flag views
	// ****************************************
	logic math_fault_flag;
	logic bad_address_flag;
	logic stack_fault_flag;
	logic clock_loss_flag;
	logic nest_bit;

	assign math_fault_flag = trap_if.flags[3]; // RL1
	assign bad_address_flag = trap_if.flags[2]; // RL2
	assign stack_fault_flag = trap_if.flags[1]; // RL3
	assign clock_loss_flag = trap_if.flags[0]; // RL4
	assign nest_bit = upper_q[tsc_pkg::UPPER_W-1];

	// ****************************************
	// trap register word
	// ****************************************
	logic [15:0] trap_word;
	logic [15:0] rdata_d;

	// bit 0 is never stored, so it reads 0
	assign trap_word = {upper_q, 5'h00} | tsc_place(trap_if.flags); // RL5

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata_d = 16'h0000;
		if (rd_in) begin
			if (hit_trap) begin
				rdata_d = trap_word; // RL5
			end else if (hit_stat) begin
				rdata_d = tsc_place(stat_if.flags);
			end else if (hit_mask) begin
				rdata_d = tsc_place(mask_q);
			end
		end
	end

	// ****************************************
	// read data register
	// ****************************************
	// read data stand one cycle only, zero otherwise
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			rdata_out <= tsc_pkg::TRAP_RESET; // RL6
		end else begin
			rdata_out <= rdata_d;
		end
	end

	// ****************************************
	// interrupt line
	// ****************************************
	// irq lags status by one cycle to keep the output a flop
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			irq_out <= 1'b0; // RL6
		end else begin
			irq_out <= |pending;
		end
	end

	// ****************************************
	// trap flag copy
	// ****************************************
	// one cycle behind the register, like every other top output
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			trap_flags_out <= tsc_pkg::FLAG_RESET; // RL6
		end else begin
			trap_flags_out <= {math_fault_flag, bad_address_flag, stack_fault_flag, clock_loss_flag};
		end
	end

	// ****************************************
	// nesting control copy
	// ****************************************
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			nest_disable_out <= 1'b0; // RL6
		end else begin
			nest_disable_out <= nest_bit;
		end
	end
endmodule : tsc_trap_status_control
`default_nettype wire

// ===== design/tsc_pkg.sv
`default_nettype none
package tsc_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned NFLAG = 4;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] TRAP_OFF = 4'h0;
	localparam logic [3:0] STAT_OFF = 4'h4;
	localparam logic [3:0] MASK_OFF = 4'h8;

	// ****************************************
	// field positions in the trap register
	// ****************************************
	localparam int unsigned CLOCK_LOSS_BIT = 1;
	localparam int unsigned STACK_FAULT_BIT = 2;
	localparam int unsigned BAD_ADDRESS_BIT = 3;
	localparam int unsigned MATH_FAULT_BIT = 4;
	localparam int unsigned UPPER_LSB = 5;
	localparam int unsigned UPPER_W = 11;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] TRAP_RESET = 16'h0000;
	localparam logic [3:0] FLAG_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [10:0] UPPER_RESET = 11'h000;
endpackage : tsc_pkg
`default_nettype wire

// ===== design/tsc_flag_if.sv
`default_nettype none
interface tsc_flag_if #(
	parameter int unsigned N = 4
);
	logic [N-1:0] event_set;
	logic load;
	logic [N-1:0] load_val;
	logic [N-1:0] flags;

	modport bank (
		input event_set,
		input load,
		input load_val,
		output flags
	);
	modport ctrl (
		output event_set,
		output load,
		output load_val,
		input flags
	);
endinterface : tsc_flag_if
`default_nettype wire

// ===== design/tsc_flag_bank.sv
`default_nettype none
module tsc_flag_bank #(
	parameter int unsigned N = 4,
	parameter logic [N-1:0] RESET_VAL = '0
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	tsc_flag_if.bank port_if
);
	// ****************************************
	// sticky flags
	// ****************************************
	logic [N-1:0] flags_q;
	logic [N-1:0] flags_d;

	// event ored in after the load so a set in the clearing cycle survives
	always_comb begin
		flags_d = port_if.load ? port_if.load_val : flags_q;
		flags_d = flags_d | port_if.event_set;
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			flags_q <= RESET_VAL;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign port_if.flags = flags_q;
endmodule : tsc_flag_bank
`default_nettype wire

// ===== verif/tsc_asserts.sv
`default_nettype none
module tsc_asserts (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic math_fault_in,
	input wire logic bad_address_in,
	input wire logic stack_fault_in,
	input wire logic clock_loss_in,
	input wire logic [15:0] rdata_out,
	input wire logic [3:0] trap_flags_out,
	input wire logic nest_disable_out,
	input wire logic irq_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);
	property p_math;
		math_fault_in |=> ##1 trap_flags_out[3];
	endproperty
	property p_math_cause;
		$rose(trap_flags_out[3]) |-> $past(math_fault_in, 2) || ($past(wr_in, 2) && $past(wdata_in[4], 2));
	endproperty
	property p_addr;
		bad_address_in |=> ##1 trap_flags_out[2];
	endproperty
	property p_stack;
		stack_fault_in |=> ##1 trap_flags_out[1];
	endproperty
	property p_clock;
		clock_loss_in |=> ##1 trap_flags_out[0];
	endproperty
	property p_bit0;
		rdata_out[0] == 1'b0;
	endproperty
	// the math and clock loss flags may only drop two edges after a clearing write
	property p_sticky;
		$fell(trap_flags_out[3]) |-> $past(wr_in, 2) && $past(addr_in, 2) == 4'h0 && !$past(wdata_in[4], 2);
	endproperty
	property p_sticky_clock;
		$fell(trap_flags_out[0]) |-> $past(wr_in, 2) && $past(addr_in, 2) == 4'h0 && !$past(wdata_in[1], 2);
	endproperty
	property p_reset_zero;
		$rose(rstn_in) |-> trap_flags_out == 4'h0 && rdata_out == 16'h0000 && !irq_out && !nest_disable_out;
	endproperty
	a_math: assert property (p_math) else $error("math flag not set");
	a_math_cause: assert property (p_math_cause) else $error("math flag set without cause");
	a_addr: assert property (p_addr) else $error("address flag not set");
	a_stack: assert property (p_stack) else $error("stack flag not set");
	a_clock: assert property (p_clock) else $error("clock loss flag not set");
	a_bit0: assert property (p_bit0) else $error("bit 0 read as 1");
	a_sticky: assert property (p_sticky) else $error("math flag dropped without clear");
	a_sticky_clock: assert property (p_sticky_clock) else $error("clock loss flag dropped without clear");
	a_reset_zero: assert property (p_reset_zero) else $error("output not zero after reset");
	c_math: cover property (math_fault_in);
	c_irq: cover property (irq_out);
	c_stat: cover property (rd_in && addr_in == 4'h4);
endmodule : tsc_asserts
bind tsc_trap_status_control tsc_asserts u_tsc_asserts (.core_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in,
	.rd_in, .math_fault_in, .bad_address_in, .stack_fault_in, .clock_loss_in, .rdata_out, .trap_flags_out,
	.nest_disable_out, .irq_out);
`default_nettype wire

// ===== verif/tsc_trap_status_control_tb_top.sv
`default_nettype none
module tsc_trap_status_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [15:0] rdata;
	logic [3:0] flags;
	logic nest;
	logic irq;
	int fails = 0;
	int comparisons = 0;
	always #12.5 clk = ~clk;
	tsc_trap_status_control u_tsc_trap_status_control (.core_clk_in(clk), .rstn_in(rstn), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .math_fault_in(ev[3]), .bad_address_in(ev[2]),
		.stack_fault_in(ev[1]), .clock_loss_in(ev[0]), .rdata_out(rdata), .trap_flags_out(flags),
		.nest_disable_out(nest), .irq_out(irq));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask : rd_reg
	task automatic wrap_up;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		fails++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(4'h0, 16'h0000);
		rd_reg(4'h4, 16'h0000);
		rd_reg(4'h8, 16'h0000);
		chk("flags", 16'h0000, {12'h000, flags});
		$display("reset test done");
		wr_reg(4'h0, 16'hffff);
		rd_reg(4'h0, 16'hfffe);
		chk("nest", 16'h0001, {15'h0000, nest});
		wr_reg(4'hc, 16'hffff);
		rd_reg(4'hc, 16'h0000);
		wr_reg(4'h0, 16'h0000);
		rd_reg(4'h0, 16'h0000);
		wr_reg(4'h8, 16'h0002);
		rd_reg(4'h8, 16'h0002);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ev <= 4'h1 << i;
			@(posedge clk);
			ev <= 4'h0;
			repeat (3) @(posedge clk);
			rd_reg(4'h0, 16'h0002 << i);
			chk("flags", 16'h0001 << i, {12'h000, flags});
			chk("irq", {15'h0000, i == 0}, {15'h0000, irq});
			rd_reg(4'h4, 16'h0002 << i);
			rd_reg(4'h4, 16'h0000);
			chk("irq", 16'h0000, {15'h0000, irq});
			wr_reg(4'h0, 16'h0000);
			rd_reg(4'h0, 16'h0000);
		end
		$display("trap test done");
		// set wins over a clearing write in the same cycle
		@(posedge clk);
		wr <= 1'b1;
		addr <= 4'h0;
		wdata <= 16'h8000;
		ev <= 4'h8;
		@(posedge clk);
		wr <= 1'b0;
		ev <= 4'h0;
		wr_reg(4'h8, 16'h001e);
		rd_reg(4'h0, 16'h8010);
		chk("irq", 16'h0001, {15'h0000, irq});
		chk("nest", 16'h0001, {15'h0000, nest});
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(4'h0, 16'h0000);
		rd_reg(4'h4, 16'h0000);
		rd_reg(4'h8, 16'h0000);
		chk("flags", 16'h0000, {12'h000, flags});
		chk("nest", 16'h0000, {15'h0000, nest});
		chk("irq", 16'h0000, {15'h0000, irq});
		$display("set priority and mid run reset test done");
		wrap_up();
	end
endmodule : tsc_trap_status_control_tb_top
`default_nettype wire
